// [verilog/src_learn_storm_pkg.sv]
// Constants, register map and frame carriers for the source learning
// and storm policing step. Assumes a 50 MHz core clock.
package src_learn_storm_pkg;
  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int NPORT = 12;
  localparam int CPU_PORT = 11;
  localparam int NQ = 8;
  localparam int NSTORM = 4;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_AGEN = 8'h00;
  localparam logic [7:0] OFS_CPU_QUEUE_SELECT_CONFIG = 8'h04;
  localparam logic [7:0] OFS_BURST = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_STORM0 = 8'h10;
  localparam logic [7:0] OFS_PORT0 = 8'h40;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int PC_ENA = 0;
  localparam int PC_AUTO = 1;
  localparam int PC_CPU = 2;
  localparam int PC_DROP = 3;
  localparam int PC_LIM_CPU = 4;
  localparam int PC_LIM_DROP = 5;
  localparam int PC_LCK_CPU = 6;
  localparam int PC_LCK_DROP = 7;
  localparam logic [7:0] PORT_CFG_RST = 8'h03;
  localparam logic [10:0] BURST_RST = 11'h010;
  localparam int SC_UNIT = 0;
  localparam int SC_RATE_LSB = 4;
  localparam int SC_MODE_LSB = 8;
  localparam logic [3:0] RATE_MAX = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAST_BASE_NS = 1000000;
  localparam int FAST_BASE_CYC = FAST_BASE_NS / CLK_PERIOD_NS;
  localparam logic [9:0] FAST_PER_SLOW = 10'h3e8;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] physical_ingress_port;
    logic [3:0] logical_ingress_port;
    logic [NPORT-1:0] destination_port_set;
    logic [NQ-1:0] cpu_queue_mask;
    logic learn_dis;
    logic pol_no_learn;
    logic hit;
    logic locked;
    logic [3:0] idx;
    logic src_discard;
    logic cpu_copy;
    logic limit_over;
    logic domain;
    logic flooded;
    logic bcast;
    logic bit40;
    logic port_group_entry_cpu;
  } frame_in_t;
  typedef struct packed {
    logic [NPORT-1:0] destination_port_set;
    logic [NQ-1:0] cpu_queue_mask;
    logic learn_req;
    logic learn_domain;
    logic policed;
  } frame_out_t;
endpackage : src_learn_storm_pkg

// [verilog/src_learn_storm.sv]
// Source address learning and storm policing analyzer step.
// Assumes frame info arrives one cycle per FRM_VALID with no stall;
// configuration comes over an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module src_learn_storm #(
  parameter int FAST_CYC = src_learn_storm_pkg::FAST_BASE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic FRM_VALID,
  input wire src_learn_storm_pkg::frame_in_t FRM_IN,
  output logic RES_VALID,
  output src_learn_storm_pkg::frame_out_t RES_OUT,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  localparam int NP = src_learn_storm_pkg::NPORT;
  localparam int CP = src_learn_storm_pkg::CPU_PORT;
  localparam int NS = src_learn_storm_pkg::NSTORM;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] port_cfg_r [NP];
  logic [10:0] storm_cfg_r [NS];
  logic ignore_flags_r;
  logic [10:0] cpu_queue_select_config_r;
  logic [10:0] burst_r;
  logic [10:0] tok_r [NS];
  logic [NS-1:0] empty;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;

  // Readies are flops: low from take until the response handshake
  assign do_wr = aw_held_r && w_held_r && !BVALID;

  // Byte lanes not strobed keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= src_learn_storm_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held_r <= 1'b1;
        WREADY <= 1'b0;
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_hit ? src_learn_storm_pkg::RESP_OKAY
                        : src_learn_storm_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_r == src_learn_storm_pkg::OFS_AGEN ||
        awaddr_r == src_learn_storm_pkg::OFS_CPU_QUEUE_SELECT_CONFIG ||
        awaddr_r == src_learn_storm_pkg::OFS_BURST) begin
      wr_hit = 1'b1;
    end
    for (int i = 0; i < NS; i++) begin
      if (awaddr_r == src_learn_storm_pkg::OFS_STORM0 + 8'(4*i)) begin
        wr_hit = 1'b1;
      end
    end
    for (int p = 0; p < NP; p++) begin
      if (awaddr_r == src_learn_storm_pkg::OFS_PORT0 + 8'(4*p)) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ignore_flags_r <= 1'b0;
      cpu_queue_select_config_r <= 11'h0;
      burst_r <= src_learn_storm_pkg::BURST_RST;
    end else if (do_wr) begin
      if (awaddr_r == src_learn_storm_pkg::OFS_AGEN) begin
        ignore_flags_r <= 1'(merge({31'h0, ignore_flags_r}, wdata_r, wstrb_r));
      end
      if (awaddr_r == src_learn_storm_pkg::OFS_CPU_QUEUE_SELECT_CONFIG) begin
        cpu_queue_select_config_r <= 11'(merge({21'h0, cpu_queue_select_config_r}, wdata_r, wstrb_r));
      end
      if (awaddr_r == src_learn_storm_pkg::OFS_BURST) begin
        burst_r <= 11'(merge({21'h0, burst_r}, wdata_r, wstrb_r));
      end
    end
  end

  // Storm config and per-port learn config, one register each
  for (genvar i = 0; i < NS; i++) begin : g_storm_cfg
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        storm_cfg_r[i] <= 11'h0;
      end else if (do_wr &&
                   awaddr_r == src_learn_storm_pkg::OFS_STORM0 + 8'(4*i)) begin
        storm_cfg_r[i] <= 11'(merge({21'h0, storm_cfg_r[i]}, wdata_r, wstrb_r));
      end
    end
  end
  for (genvar p = 0; p < NP; p++) begin : g_port_cfg
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        port_cfg_r[p] <= src_learn_storm_pkg::PORT_CFG_RST;
      end else if (do_wr &&
                   awaddr_r == src_learn_storm_pkg::OFS_PORT0 + 8'(4*p)) begin
        port_cfg_r[p] <= 8'(merge({24'h0, port_cfg_r[p]}, wdata_r, wstrb_r));
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (ARADDR)
      src_learn_storm_pkg::OFS_AGEN: rd_val = {31'h0, ignore_flags_r};
      src_learn_storm_pkg::OFS_CPU_QUEUE_SELECT_CONFIG: rd_val = {21'h0, cpu_queue_select_config_r};
      src_learn_storm_pkg::OFS_BURST: rd_val = {21'h0, burst_r};
      src_learn_storm_pkg::OFS_STATUS: rd_val = {28'h0, empty};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NS; i++) begin
          if (ARADDR == src_learn_storm_pkg::OFS_STORM0 + 8'(4*i)) begin
            rd_hit = 1'b1;
            rd_val = {21'h0, storm_cfg_r[i]};
          end
        end
        for (int p = 0; p < NP; p++) begin
          if (ARADDR == src_learn_storm_pkg::OFS_PORT0 + 8'(4*p)) begin
            rd_hit = 1'b1;
            rd_val = {24'h0, port_cfg_r[p]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= src_learn_storm_pkg::RESP_OKAY;
      ARREADY <= 1'b1;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_val;
      RRESP <= rd_hit ? src_learn_storm_pkg::RESP_OKAY
                      : src_learn_storm_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------
  // Source learning
  // ----------------------------------------
  logic [7:0] pc;
  logic learn_ok;
  logic moved;
  logic norm;
  logic over;
  logic lmove;
  logic cpu_lrn;
  logic [NP-1:0] destination_port_set_lrn;
  logic [7:0] learn_cpu_queue;

  // Port numbers past the last port read as learning off
  assign pc = FRM_IN.physical_ingress_port < 4'(NP) ? port_cfg_r[FRM_IN.physical_ingress_port] : 8'h00;
  assign learn_ok = !FRM_IN.learn_dis && !FRM_IN.pol_no_learn &&
                    pc[src_learn_storm_pkg::PC_ENA];
  assign moved = FRM_IN.idx != FRM_IN.logical_ingress_port;
  assign norm = (!FRM_IN.hit || (!FRM_IN.locked && moved)) &&
                !FRM_IN.limit_over;
  assign over = (!FRM_IN.hit || (!FRM_IN.locked && moved)) &&
                FRM_IN.limit_over;
  assign lmove = FRM_IN.hit && FRM_IN.locked && moved;

  // Discards act first so a CPU copy on the same frame survives
  always_comb begin
    destination_port_set_lrn = FRM_IN.destination_port_set;
    learn_cpu_queue = FRM_IN.cpu_queue_mask;
    cpu_lrn = 1'b0;
    if (learn_ok) begin
      if ((norm && pc[src_learn_storm_pkg::PC_DROP]) ||
          (over && pc[src_learn_storm_pkg::PC_LIM_DROP]) ||
          (lmove && pc[src_learn_storm_pkg::PC_LCK_DROP])) begin
        destination_port_set_lrn = '0;
      end
      if ((norm && pc[src_learn_storm_pkg::PC_CPU]) ||
          (over && pc[src_learn_storm_pkg::PC_LIM_CPU])) begin
        destination_port_set_lrn[CP] = 1'b1;
        learn_cpu_queue[cpu_queue_select_config_r[2:0]] = 1'b1;
        cpu_lrn = 1'b1;
      end
      if (lmove && pc[src_learn_storm_pkg::PC_LCK_CPU]) begin
        destination_port_set_lrn[CP] = 1'b1;
        learn_cpu_queue[cpu_queue_select_config_r[6:4]] = 1'b1;
        cpu_lrn = 1'b1;
      end
    end
  end

  logic [NP-1:0] destination_port_set_smac;
  logic [7:0] cpu_queue_mask_smac;

  always_comb begin
    destination_port_set_smac = destination_port_set_lrn;
    cpu_queue_mask_smac = learn_cpu_queue;
    if (FRM_IN.hit && !ignore_flags_r) begin
      if (FRM_IN.src_discard) begin
        destination_port_set_smac = '0;
      end
      if (FRM_IN.cpu_copy) begin
        cpu_queue_mask_smac[cpu_queue_select_config_r[10:8]] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Storm policers
  // ----------------------------------------
  logic [$clog2(FAST_CYC)-1:0] fast_cnt_r;
  logic [9:0] slow_cnt_r;
  logic fast_tick;
  logic slow_tick;
  logic [NS-1:0] cls;
  logic [NS-1:0] act;
  logic [NS-1:0] hit_lim;
  logic [1:0] mode_or;

  assign fast_tick = fast_cnt_r == ($clog2(FAST_CYC))'(FAST_CYC - 1);
  assign slow_tick = fast_tick && slow_cnt_r == src_learn_storm_pkg::FAST_PER_SLOW - 10'h1;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fast_cnt_r <= '0;
      slow_cnt_r <= 10'h0;
    end else begin
      fast_cnt_r <= fast_tick ? '0 : fast_cnt_r + 1'b1;
      if (slow_tick) begin
        slow_cnt_r <= 10'h0;
      end else if (fast_tick) begin
        slow_cnt_r <= slow_cnt_r + 10'h1;
      end
    end
  end

  // Classes follow the destination address and learn-CPU outcome
  assign cls[0] = FRM_IN.flooded && FRM_IN.bcast;
  assign cls[1] = FRM_IN.flooded && FRM_IN.bit40 && !FRM_IN.bcast;
  assign cls[2] = FRM_IN.flooded && !FRM_IN.bit40;
  assign cls[3] = cpu_lrn;

  for (genvar i = 0; i < NS; i++) begin : g_storm
    logic [3:0] rate;
    logic [11:0] fill;
    logic [10:0] lvl;
    logic tick;
    assign rate = storm_cfg_r[i][7:4] > src_learn_storm_pkg::RATE_MAX
                  ? src_learn_storm_pkg::RATE_MAX : storm_cfg_r[i][7:4];
    assign tick = storm_cfg_r[i][src_learn_storm_pkg::SC_UNIT]
                  ? fast_tick : slow_tick;
    assign fill = {1'b0, tok_r[i]} + (12'h1 << rate);
    assign lvl = !tick ? tok_r[i] :
                 fill > {1'b0, burst_r} ? burst_r : fill[10:0];
    assign empty[i] = lvl == 11'h0;
    assign act[i] = FRM_VALID && cls[i] && storm_cfg_r[i][9:8] != 2'h0;
    assign hit_lim[i] = act[i] && empty[i];
    // Shared by all ports: one bucket counts whole-switch traffic
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        tok_r[i] <= 11'h0;
      end else if (act[i] && !empty[i]) begin
        tok_r[i] <= lvl - 11'h1;
      end else begin
        tok_r[i] <= lvl;
      end
    end
  end

  always_comb begin
    mode_or = 2'h0;
    for (int i = 0; i < NS; i++) begin
      if (hit_lim[i]) begin
        mode_or = mode_or | storm_cfg_r[i][9:8];
      end
    end
  end

  // ----------------------------------------
  // Result stage
  // ----------------------------------------
  src_learn_storm_pkg::frame_out_t res_nxt;

  always_comb begin
    res_nxt.destination_port_set = destination_port_set_smac;
    res_nxt.cpu_queue_mask = cpu_queue_mask_smac;
    res_nxt.learn_req = learn_ok && norm && pc[src_learn_storm_pkg::PC_AUTO];
    res_nxt.learn_domain = FRM_IN.domain;
    res_nxt.policed = |hit_lim;
    if (mode_or[0] && !FRM_IN.port_group_entry_cpu) begin
      res_nxt.cpu_queue_mask = '0;
    end
    if (mode_or[1]) begin
      res_nxt.destination_port_set = '0;
      res_nxt.destination_port_set[CP] = FRM_IN.port_group_entry_cpu && destination_port_set_smac[CP];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RES_VALID <= 1'b0;
      RES_OUT <= '0;
    end else begin
      RES_VALID <= FRM_VALID;
      RES_OUT <= FRM_VALID ? res_nxt : '0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_flag_skip: assert property (FRM_VALID && FRM_IN.learn_dis |=> !RES_OUT.learn_req)
    else $error("learn request despite learn disable");
  a_port_gate: assert property (FRM_VALID && !pc[0] |=> !RES_OUT.learn_req)
    else $error("learn request on disabled port");
  a_pol_skip: assert property (FRM_VALID && FRM_IN.pol_no_learn |=> !RES_OUT.learn_req)
    else $error("learn request on policed frame");
  a_auto_insert: assert property (FRM_VALID && learn_ok && norm && pc[1]
                                  |=> RES_OUT.learn_req &&
                                  RES_OUT.learn_domain == $past(FRM_IN.domain))
    else $error("auto learn missed");
  a_kinds_excl: assert property (FRM_VALID |-> !(norm && over) && !(norm && lmove))
    else $error("learn kinds overlap");
  a_copy_cpu: assert property (FRM_VALID && learn_ok && norm && pc[2]
                               |-> destination_port_set_lrn[CP] && learn_cpu_queue[cpu_queue_select_config_r[2:0]])
    else $error("learn copy to CPU missing");
  a_lock_drop: assert property (FRM_VALID && learn_ok && lmove && pc[7] && !pc[6]
                                |-> destination_port_set_lrn == '0)
    else $error("locked move discard missed");
  a_flag_ignore: assert property (FRM_VALID && ignore_flags_r |-> destination_port_set_smac == destination_port_set_lrn)
    else $error("entry flags used while ignored");
  a_storm_drop: assert property (FRM_VALID && |(act & empty)
                                 |=> RES_OUT.policed && RES_VALID)
    else $error("exceeded policer did not police");
  // A burst write may lower the cap below the level until the next tick
  a_bucket_cap: assert property (tok_r[0] <= burst_r
                                 |=> burst_r != $past(burst_r) || tok_r[0] <= burst_r)
    else $error("storm bucket above burst");
  a_cpu_keep: assert property (FRM_VALID && FRM_IN.port_group_entry_cpu && destination_port_set_smac[CP]
                               |=> RES_OUT.destination_port_set[CP])
    else $error("CPU copy lost to storm policing");
endmodule : src_learn_storm
`default_nettype wire

// [dv/frame_feeder.sv]
// Model of the upstream analyzer steps that hand frame info to the
// learning step. Assumes the bench queues frames; one goes out per clock.
`timescale 1ns/1ps
`default_nettype none
module frame_feeder (
  input wire logic clk,
  output logic frm_valid,
  output src_learn_storm_pkg::frame_in_t frm_in
);
  // ----------------------------------------
  // Frame queue
  // ----------------------------------------
  src_learn_storm_pkg::frame_in_t pend[$];

  initial begin
    frm_valid = 1'b0;
    frm_in = '0;
  end

  task automatic push(input src_learn_storm_pkg::frame_in_t f);
    pend.push_back(f);
  endtask : push

  // ----------------------------------------
  // Issue
  // ----------------------------------------
  // Idle fields toggle, so stale info never looks like a valid frame
  always @(posedge clk) begin
    if (pend.size() > 0) begin
      frm_valid <= 1'b1;
      frm_in <= pend.pop_front();
    end else begin
      frm_valid <= 1'b0;
      frm_in <= ~frm_in;
    end
  end
endmodule : frame_feeder
`default_nettype wire

// [dv/src_learn_storm_bench.sv]
// Self-checking bench for the source learning and storm policing step.
// Assumes frame_feeder upstream and a bench AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module src_learn_storm_bench;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] fl;
    logic [3:0] idx;
    logic [11:0] edest;
    logic [7:0] ecpuq;
    logic elr;
  } row_t;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic FRM_VALID;
  src_learn_storm_pkg::frame_in_t FRM_IN;
  logic RES_VALID;
  src_learn_storm_pkg::frame_out_t RES_OUT;
  logic [7:0] AWADDR = 8'h00;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b0;
  logic [7:0] ARADDR = 8'h00;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b0;
  int errors = 0;
  int checks = 0;
  row_t rows [15];

  always #10 CORE_CLK = ~CORE_CLK;

  frame_feeder u_feeder (.clk(CORE_CLK), .frm_valid(FRM_VALID), .frm_in(FRM_IN));

  // Short refill tick puts slow refills 20000 cycles apart, inside the watchdog
  src_learn_storm #(.FAST_CYC(20)) u_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .FRM_VALID(FRM_VALID), .FRM_IN(FRM_IN),
    .RES_VALID(RES_VALID), .RES_OUT(RES_OUT), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ra;
    logic rw;
    logic rb;
    logic [1:0] rr;
    @(posedge CORE_CLK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hf;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      #1;
      ra = AWREADY;
      rw = WREADY;
      rb = BVALID;
      rr = BRESP;
      @(posedge CORE_CLK);
      if (ra) AWVALID <= 1'b0;
      if (rw) WVALID <= 1'b0;
    end while (!rb);
    BREADY <= 1'b0;
    cmp({29'h0, rb, rr}, {29'h0, 1'b1, er});
  endtask : axi_write

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ra;
    logic rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      #1;
      ra = ARREADY;
      rv = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CORE_CLK);
      if (ra) ARVALID <= 1'b0;
    end while (!rv);
    RREADY <= 1'b0;
    cmp({29'h0, rv, r}, {29'h0, 1'b1, er});
    cmp(d & m, ed);
  endtask : rd_chk

  function automatic src_learn_storm_pkg::frame_out_t mk_out(input logic [11:0] d,
      input logic [7:0] q, input logic lr, input logic pol);
    mk_out = '0;
    mk_out.destination_port_set = d;
    mk_out.cpu_queue_mask = q;
    mk_out.learn_req = lr;
    mk_out.learn_domain = lr;
    mk_out.policed = pol;
  endfunction : mk_out

  // Domain only matters when an insert is requested
  task automatic expect_res(input src_learn_storm_pkg::frame_out_t e);
    src_learn_storm_pkg::frame_out_t g;
    @(posedge CORE_CLK);
    #1;
    g = RES_OUT;
    if (!e.learn_req) g.learn_domain = e.learn_domain;
    cmp(32'({RES_VALID, g}), 32'({1'b1, e}));
  endtask : expect_res

  task automatic send(input src_learn_storm_pkg::frame_in_t f);
    #1;
    u_feeder.push(f);
  endtask : send

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #1_000_000;
    errors++;
    stop_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    src_learn_storm_pkg::frame_in_t f;
    src_learn_storm_pkg::frame_in_t b;
    int n;
    logic [31:0] st;
    // Flags: ign, hit, locked, over limit, learn off, policed no learn, src discard, cpu copy
    rows[0] = '{8'h03, 8'b00000000, 4'h0, 12'h00f, 8'h00, 1'b1};
    rows[1] = '{8'h0b, 8'b00000000, 4'h0, 12'h000, 8'h00, 1'b1};
    rows[2] = '{8'h0d, 8'b00000000, 4'h0, 12'h800, 8'h04, 1'b0};
    rows[3] = '{8'h03, 8'b00001000, 4'h0, 12'h00f, 8'h00, 1'b0};
    rows[4] = '{8'h0e, 8'b00000000, 4'h0, 12'h00f, 8'h00, 1'b0};
    rows[5] = '{8'h03, 8'b00000100, 4'h0, 12'h00f, 8'h00, 1'b0};
    rows[6] = '{8'h31, 8'b00010000, 4'h0, 12'h800, 8'h04, 1'b0};
    rows[7] = '{8'hc1, 8'b01100000, 4'h3, 12'h800, 8'h20, 1'b0};
    rows[8] = '{8'hc1, 8'b01100000, 4'h1, 12'h00f, 8'h00, 1'b0};
    rows[9] = '{8'h03, 8'b01000000, 4'h3, 12'h00f, 8'h00, 1'b1};
    rows[10] = '{8'h03, 8'b01000000, 4'h1, 12'h00f, 8'h00, 1'b0};
    rows[11] = '{8'h01, 8'b01000011, 4'h1, 12'h000, 8'h80, 1'b0};
    rows[12] = '{8'h01, 8'b11000011, 4'h1, 12'h00f, 8'h00, 1'b0};
    rows[13] = '{8'h0d, 8'b01000010, 4'h3, 12'h000, 8'h04, 1'b0};
    rows[14] = '{8'h03, 8'b00010000, 4'h0, 12'h00f, 8'h00, 1'b0};
    b = '0;
    b.physical_ingress_port = 4'h1;
    b.logical_ingress_port = 4'h1;
    b.destination_port_set = 12'h00f;
    b.domain = 1'b1;
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd_chk(src_learn_storm_pkg::OFS_AGEN, 32'h1, 32'h0, src_learn_storm_pkg::RESP_OKAY);
    rd_chk(src_learn_storm_pkg::OFS_BURST, 32'h7ff, 32'h10, src_learn_storm_pkg::RESP_OKAY);
    rd_chk(8'h44, 32'hff, 32'h03, src_learn_storm_pkg::RESP_OKAY);
    axi_write(8'h20, 32'h1, src_learn_storm_pkg::RESP_SLVERR);
    rd_chk(8'h20, 32'hffffffff, 32'h0, src_learn_storm_pkg::RESP_SLVERR);
    axi_write(src_learn_storm_pkg::OFS_CPU_QUEUE_SELECT_CONFIG, 32'h752, src_learn_storm_pkg::RESP_OKAY);
    foreach (rows[i]) begin
      axi_write(8'h44, {24'h0, rows[i].cfg}, src_learn_storm_pkg::RESP_OKAY);
      axi_write(src_learn_storm_pkg::OFS_AGEN, {31'h0, rows[i].fl[7]},
                src_learn_storm_pkg::RESP_OKAY);
      f = b;
      {f.hit, f.locked, f.limit_over, f.learn_dis} = rows[i].fl[6:3];
      {f.pol_no_learn, f.src_discard, f.cpu_copy} = rows[i].fl[2:0];
      f.idx = rows[i].idx;
      send(f);
      @(posedge CORE_CLK);
      expect_res(mk_out(rows[i].edest, rows[i].ecpuq, rows[i].elr, 1'b0));
    end
    // Storm policer 0 on broadcast floods, two tokens at most
    b.learn_dis = 1'b1;
    b.flooded = 1'b1;
    b.bcast = 1'b1;
    b.bit40 = 1'b1;
    axi_write(src_learn_storm_pkg::OFS_BURST, 32'h2, src_learn_storm_pkg::RESP_OKAY);
    axi_write(src_learn_storm_pkg::OFS_STORM0, 32'h310, src_learn_storm_pkg::RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      f = b;
      f.physical_ingress_port = 4'(i % 12);
      send(f);
    end
    repeat (30) @(posedge CORE_CLK);
    // Wait for a refill so the next one is a whole slow period away
    n = 0;
    do begin
      rd_chk(src_learn_storm_pkg::OFS_STATUS, 32'h0, 32'h0, src_learn_storm_pkg::RESP_OKAY);
      st = RDATA;
      n++;
    end while (st[0] && n < 8000);
    cmp({31'h0, st[0]}, 32'h0);
    f = b;
    f.physical_ingress_port = 4'h2;
    send(f);
    f.physical_ingress_port = 4'h5;
    send(f);
    f.physical_ingress_port = 4'h9;
    f.port_group_entry_cpu = 1'b1;
    f.destination_port_set = 12'h80f;
    f.cpu_queue_mask = 8'h01;
    send(f);
    @(posedge CORE_CLK);
    expect_res(mk_out(12'h00f, 8'h00, 1'b0, 1'b0));
    expect_res(mk_out(12'h00f, 8'h00, 1'b0, 1'b0));
    expect_res(mk_out(12'h800, 8'h01, 1'b0, 1'b1));
    for (int c = 0; c < 3; c++) begin
      f = b;
      f.bcast = 1'b0;
      f.bit40 = (c == 0);
      f.flooded = (c != 2);
      send(f);
    end
    @(posedge CORE_CLK);
    repeat (3) expect_res(mk_out(12'h00f, 8'h00, 1'b0, 1'b0));
    for (int m = 1; m < 4; m++) begin
      axi_write(src_learn_storm_pkg::OFS_STORM0, 32'h010 | (m << 8),
                src_learn_storm_pkg::RESP_OKAY);
      f = b;
      f.cpu_queue_mask = 8'h02;
      send(f);
      @(posedge CORE_CLK);
      expect_res(mk_out(m[1] ? 12'h000 : 12'h00f, m[0] ? 8'h00 : 8'h02, 1'b0, 1'b1));
    end
    rd_chk(src_learn_storm_pkg::OFS_STATUS, 32'h1, 32'h1, src_learn_storm_pkg::RESP_OKAY);
    // Fast unit refills within one short tick; slow unit would stay empty
    axi_write(src_learn_storm_pkg::OFS_STORM0, 32'h311, src_learn_storm_pkg::RESP_OKAY);
    repeat (25) @(posedge CORE_CLK);
    rd_chk(src_learn_storm_pkg::OFS_STATUS, 32'h1, 32'h0, src_learn_storm_pkg::RESP_OKAY);
    // Reset in mid-run brings outputs and registers back
    @(posedge CORE_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #1;
    cmp({28'h0, RES_VALID, AWREADY, WREADY, ARREADY}, 32'h7);
    cmp(32'(RES_OUT), 32'h0);
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd_chk(8'h44, 32'hff, 32'h03, src_learn_storm_pkg::RESP_OKAY);
    rd_chk(src_learn_storm_pkg::OFS_BURST, 32'h7ff, 32'h10,
           src_learn_storm_pkg::RESP_OKAY);
    stop_test();
  end
endmodule : src_learn_storm_bench
`default_nettype wire
